/* core/conv_timing_pkg.sv */
// Package of constants and types for the converter core timing block.
package conv_timing_pkg;

  // ==========================================================================
  // Clock division
  // ==========================================================================
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_2 = 2'h1;
  localparam logic [1:0] DIV_BY_4 = 2'h2;
  localparam logic [1:0] DIV_RESET = DIV_BY_1;

  // ==========================================================================
  // Latencies and pulse widths in frame clock cycles
  // ==========================================================================
  localparam int CORE_LATENCY_FRAMES = 7;
  localparam int FLAG_ASSERT_FRAMES  = 8;
  localparam int FLAG_EXTRA_MAX      = 15;
  localparam int SYSREF_MIN_FRAMES   = 2;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int SAMPLE_W = 16;
  localparam logic [3:0] RELEASE_EXTRA_RESET = 4'h0;

  // Reference edge tracker states.
  typedef enum logic [1:0] {
    SR_LOW,
    SR_HIGH,
    SR_WAIT_LOW
  } sysref_state_type;

endpackage : conv_timing_pkg

/* core/delay_line.sv */
// Fixed-length delay line advanced on the frame strobe.
`timescale 1ns/1ns
`default_nettype none
module delay_line #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 7
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             adv,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // A line with no stage cannot hold a sample at all.
  if (DEPTH < 1) begin : g_depth_check
    $error("DEPTH must be at least 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stage;
  } dl_state_type;

  dl_state_type s_r;
  dl_state_type s_nxt;

  // ==========================================================================
  // Shift by one stage per frame.
  // ==========================================================================
  always_comb begin
    s_nxt = s_r;
    if (adv) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        s_nxt.stage[i] = s_r.stage[i-1];
      end
      s_nxt.stage[0] = din;
    end
  end

  // Reset clears every stage so stale data never leaves the line.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.stage[DEPTH-1];

endmodule : delay_line
`default_nettype wire

/* core/conv_timing.sv */
// Frame timing, over-range flag and reference pulse qualification.
`timescale 1ns/1ns
`default_nettype none
module conv_timing
  import conv_timing_pkg::*;
#(
  parameter int SAMPLE_WIDTH = conv_timing_pkg::SAMPLE_W
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic [1:0]              clock_divide_ratio,
  input  wire logic [SAMPLE_WIDTH-1:0] sample_in,
  input  wire logic                    sample_overrange,
  input  wire logic [3:0]              release_extra,
  input  wire logic                    pin_flag_mode,
  input  wire logic                    readback_data,
  input  wire logic                    readback_active,
  input  wire logic                    sysref,
  output logic                         frame_strobe,
  output logic [SAMPLE_WIDTH-1:0]      boundary_sample,
  output logic                         overrange_flag,
  output logic                         shared_readback_flag_pin_o,
  output logic                         shared_readback_flag_pin_oe_n,
  output logic                         sysref_event,
  output logic                         sysref_width_error
);
  import conv_timing_pkg::*;

  // A zero-width sample path cannot be built.
  if (SAMPLE_WIDTH < 1) begin : g_width_check
    $error("SAMPLE_WIDTH must be positive");
  end

  // Over-range history for the assertion delay, one bit per frame.
  localparam int OVR_HIST = FLAG_ASSERT_FRAMES;

  typedef struct packed {
    logic [2:0]          sr_sync;
    logic                sr_level;
    logic [1:0]          div_cnt;
    logic [1:0]          ratio;
    logic [OVR_HIST-1:0] ovr_hist;
    logic                flag;
    logic [4:0]          release_cnt;
    logic [3:0]          extra;
    sysref_state_type    sr_state;
    logic [1:0]          sr_frames;
    logic                sr_event;
    logic                sr_err;
    logic                pin_o;
    logic                pin_oe_n;
  } ct_state_type;

  ct_state_type s_r;
  ct_state_type s_nxt;
  logic [1:0]   rst_sync_r;
  logic         rst_int_n;
  logic         frame_tick;
  logic         ovr_late;

  // ==========================================================================
  // Reset release through two flops.
  // ==========================================================================
  // Kept apart from the state record: it is reset by the raw reset, and
  // the record is reset by its output.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_r[1];

  // A frame ends on the last input clock of each divide period.
  always_comb begin
    case (s_r.ratio)
      DIV_BY_2: frame_tick = clk_en && (s_r.div_cnt == 2'h1);
      DIV_BY_4: frame_tick = clk_en && (s_r.div_cnt == 2'h3);
      default:  frame_tick = clk_en;
    endcase
  end

  assign ovr_late = s_r.ovr_hist[OVR_HIST-1];

  // ==========================================================================
  // Next-state logic for everything except the reset synchroniser.
  // ==========================================================================
  always_comb begin
    s_nxt = s_r;
    s_nxt.sr_event = 1'b0;
    if (clk_en) begin
      // Reference sampled every enabled input clock, ahead of the divider.
      s_nxt.sr_sync = {s_r.sr_sync[1:0], sysref};
      if (s_r.sr_sync[2] == s_r.sr_sync[1]) begin
        s_nxt.sr_level = s_r.sr_sync[2];
      end
      // Ratio changes only at a frame edge so no short frame is made.
      s_nxt.div_cnt = s_r.div_cnt + 2'h1;
      if (frame_tick) begin
        s_nxt.div_cnt = 2'h0;
        s_nxt.ratio = clock_divide_ratio;
      end
      // Each qualified rising edge is an event, with widths counted in frames.
      case (s_r.sr_state)
        SR_LOW: begin
          if (s_nxt.sr_level && !s_r.sr_level) begin
            s_nxt.sr_event = 1'b1;
            s_nxt.sr_state = SR_HIGH;
            s_nxt.sr_frames = 2'h0;
          end else if (s_r.sr_frames != 2'(SYSREF_MIN_FRAMES)
                       && frame_tick) begin
            s_nxt.sr_frames = s_r.sr_frames + 2'h1;
          end
        end
        SR_HIGH: begin
          if (!s_nxt.sr_level) begin
            // Short high pulse violates the source's obligation.
            if (s_r.sr_frames < 2'(SYSREF_MIN_FRAMES)) begin
              s_nxt.sr_err = 1'b1;
            end
            s_nxt.sr_state = SR_WAIT_LOW;
            s_nxt.sr_frames = 2'h0;
          end else if (frame_tick
                       && s_r.sr_frames != 2'(SYSREF_MIN_FRAMES)) begin
            s_nxt.sr_frames = s_r.sr_frames + 2'h1;
          end
        end
        SR_WAIT_LOW: begin
          // The low phase is timed here until two frames have passed.
          if (s_nxt.sr_level) begin
            if (s_r.sr_frames < 2'(SYSREF_MIN_FRAMES)) begin
              s_nxt.sr_err = 1'b1;
            end
            s_nxt.sr_event = 1'b1;
            s_nxt.sr_state = SR_HIGH;
            s_nxt.sr_frames = 2'h0;
          end else if (s_r.sr_frames == 2'(SYSREF_MIN_FRAMES)) begin
            s_nxt.sr_state = SR_LOW;
          end else if (frame_tick) begin
            s_nxt.sr_frames = s_r.sr_frames + 2'h1;
          end
        end
        default: s_nxt.sr_state = SR_LOW;
      endcase
      if (frame_tick) begin
        // One flag history entry per frame gives the fixed rise delay.
        s_nxt.ovr_hist = {s_r.ovr_hist[OVR_HIST-2:0], sample_overrange};
        s_nxt.extra = release_extra;
        if (ovr_late) begin
          s_nxt.flag = 1'b1;
          // Countdown reloads on every over-range sample.
          s_nxt.release_cnt = 5'(s_r.extra) + 5'h1;
        end else if (s_r.release_cnt != 5'h0) begin
          s_nxt.release_cnt = s_r.release_cnt - 5'h1;
          if (s_r.release_cnt == 5'h1) begin
            s_nxt.flag = 1'b0;
          end
        end
      end
      // Shared pin carries the flag in flag mode, else readback data.
      if (pin_flag_mode) begin
        s_nxt.pin_o = s_nxt.flag;
        s_nxt.pin_oe_n = 1'b0;
      end else begin
        s_nxt.pin_o = readback_data;
        s_nxt.pin_oe_n = !readback_active;
      end
    end
  end

  // Main state register; the reset synchroniser bits are held elsewhere.
  always_ff @(posedge mclk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_r.sr_sync     <= 3'h0;
      s_r.sr_level    <= 1'b0;
      s_r.div_cnt     <= 2'h0;
      s_r.ratio       <= DIV_RESET;
      s_r.ovr_hist    <= '0;
      s_r.flag        <= 1'b0;
      s_r.release_cnt <= 5'h0;
      s_r.extra       <= RELEASE_EXTRA_RESET;
      s_r.sr_state    <= SR_LOW;
      s_r.sr_frames   <= 2'(SYSREF_MIN_FRAMES);
      s_r.sr_event    <= 1'b0;
      s_r.sr_err      <= 1'b0;
      s_r.pin_o       <= 1'b0;
      s_r.pin_oe_n    <= 1'b1;
    end else begin
      s_r.sr_sync     <= s_nxt.sr_sync;
      s_r.sr_level    <= s_nxt.sr_level;
      s_r.div_cnt     <= s_nxt.div_cnt;
      s_r.ratio       <= s_nxt.ratio;
      s_r.ovr_hist    <= s_nxt.ovr_hist;
      s_r.flag        <= s_nxt.flag;
      s_r.release_cnt <= s_nxt.release_cnt;
      s_r.extra       <= s_nxt.extra;
      s_r.sr_state    <= s_nxt.sr_state;
      s_r.sr_frames   <= s_nxt.sr_frames;
      s_r.sr_event    <= s_nxt.sr_event;
      s_r.sr_err      <= s_nxt.sr_err;
      s_r.pin_o       <= s_nxt.pin_o;
      s_r.pin_oe_n    <= s_nxt.pin_oe_n;
    end
  end

  // ==========================================================================
  // Sample pipeline to the multiframe boundary, one stage per frame.
  // ==========================================================================
  delay_line #(
    .WIDTH (SAMPLE_WIDTH),
    .DEPTH (CORE_LATENCY_FRAMES)
  ) u_core_latency (
    .mclk  (mclk),
    .rst_n (rst_int_n),
    .adv   (frame_tick),
    .din   (sample_in),
    .dout  (boundary_sample)
  );

  assign frame_strobe = frame_tick;
  assign overrange_flag = s_r.flag;
  assign shared_readback_flag_pin_o = s_r.pin_o;
  assign shared_readback_flag_pin_oe_n = s_r.pin_oe_n;
  assign sysref_event = s_r.sr_event;
  assign sysref_width_error = s_r.sr_err;

endmodule : conv_timing
`default_nettype wire

/* testbench/conv_timing_checker.sv */
// Assertions on the converter timing block ports.
`timescale 1ns/1ns
`default_nettype none
module conv_timing_checker
  import conv_timing_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [1:0] clock_divide_ratio,
  input wire logic       sample_overrange,
  input wire logic [3:0] release_extra,
  input wire logic       pin_flag_mode,
  input wire logic       readback_active,
  input wire logic       sysref,
  input wire logic       frame_strobe,
  input wire logic       overrange_flag,
  input wire logic       shared_readback_flag_pin_o,
  input wire logic       shared_readback_flag_pin_oe_n,
  input wire logic       sysref_event
);
  // ==========
  // Helpers
  // ==========
  // The core leaves reset two edges late, so checks wait three edges.
  logic [1:0] age_r;
  logic       live;
  logic       run1;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) age_r <= 2'h0;
    else if (!live) age_r <= age_r + 2'h1;
  end
  assign live = (age_r == 2'h3);
  // Flag timing is only judged with one frame per clock.
  assign run1 = live && frame_strobe && clock_divide_ratio == DIV_BY_1;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ==========
  // Assertions
  // ==========
  div1_frame_a:
    assert property (live && clk_en && $past(frame_strobe)
      && $past(clock_divide_ratio) == DIV_BY_1 |-> frame_strobe)
    else $error("frame strobe missing at divide by one");
  div4_frame_a:
    assert property (live && frame_strobe && clock_divide_ratio == DIV_BY_4
      |=> !frame_strobe [*3] ##1 frame_strobe)
    else $error("frame spacing wrong at divide by four");
  ovr_rise_a:
    assert property (run1 && sample_overrange |-> ##9 overrange_flag)
    else $error("flag late after over-range sample");
  ovr_fall_a:
    assert property (run1 && !sample_overrange && $past(sample_overrange)
      && release_extra == 4'h0 |-> ##8 overrange_flag ##1 !overrange_flag)
    else $error("flag release at minimum delay wrong");
  ovr_hold_a:
    assert property (run1 && sample_overrange && release_extra == 4'hF
      |-> ##9 overrange_flag [*8])
    else $error("flag dropped during release countdown");
  pin_flag_a:
    assert property (live && $past(pin_flag_mode) |->
      shared_readback_flag_pin_o == overrange_flag
      && !shared_readback_flag_pin_oe_n)
    else $error("shared pin does not carry the flag");
  pin_idle_a:
    assert property (live && !$past(pin_flag_mode) && !$past(readback_active)
      |-> shared_readback_flag_pin_oe_n)
    else $error("shared pin driven while idle");
  sref_event_a:
    assert property (live && $rose(sysref) |-> ##[2:6] sysref_event)
    else $error("reference rise not reported");
endmodule : conv_timing_checker

bind conv_timing conv_timing_checker conv_timing_checker_i (
  .mclk, .rst_n, .clk_en, .clock_divide_ratio, .sample_overrange,
  .release_extra, .pin_flag_mode, .readback_active, .sysref, .frame_strobe,
  .overrange_flag, .shared_readback_flag_pin_o,
  .shared_readback_flag_pin_oe_n, .sysref_event
);
`default_nettype wire

/* testbench/sysref_source.sv */
// Reference pulse source standing in for the system clock generator.
`timescale 1ns/1ns
`default_nettype none
module sysref_source (
  input  wire logic mclk,
  output logic      sysref
);
  // The line idles low between pulses.
  initial sysref = 1'b0;
  // One pulse; spans are in input clocks, so callers scale by the ratio.
  task automatic pulse(input int hi_clk, input int lo_clk);
    @(negedge mclk);
    sysref = 1'b1;
    repeat (hi_clk) @(negedge mclk);
    sysref = 1'b0;
    repeat (lo_clk) @(negedge mclk);
  endtask : pulse
endmodule : sysref_source
`default_nettype wire

/* testbench/conv_timing_tb.sv */
// Self-checking bench for the converter timing block.
`timescale 1ns/1ns
`default_nettype none
module conv_timing_tb;
  import conv_timing_pkg::*;
  logic                   mclk, rst_n, clk_en, sample_overrange, sysref;
  logic                   pin_flag_mode, readback_data, readback_active;
  logic                   frame_strobe, overrange_flag, sysref_event;
  logic                   shared_readback_flag_pin_o, sysref_width_error;
  logic                   shared_readback_flag_pin_oe_n;
  logic                   watch, prev_act, prev_mode;
  logic [1:0]             clock_divide_ratio;
  logic [3:0]             release_extra;
  logic [SAMPLE_W-1:0]    sample_in, boundary_sample;
  logic [7:0][SAMPLE_W-1:0] samp_hist;
  logic [31:0]            ovr_hist;
  int                     miscompares, compares, cycles, events;
  // ==========
  // Clock, instances
  // ==========
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  conv_timing conv_timing_i (.mclk, .rst_n, .clk_en, .clock_divide_ratio,
    .sample_in, .sample_overrange, .release_extra, .pin_flag_mode,
    .readback_data, .readback_active, .sysref, .frame_strobe,
    .boundary_sample, .overrange_flag, .shared_readback_flag_pin_o,
    .shared_readback_flag_pin_oe_n, .sysref_event, .sysref_width_error);
  sysref_source sysref_source_i (.mclk, .sysref);
  // ==========
  // Checking
  // ==========
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // Outputs are read before this edge lands; history holds what was sent.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (sysref_event === 1'b1) events <= events + 1;
    if (watch) begin
      check(boundary_sample, samp_hist[6]);
      check(overrange_flag,
        |((ovr_hist >> 8) & ((32'h2 << release_extra) - 32'h1)));
    end
    // The pin register takes the flag at the same edge as the flag itself.
    if (rst_n) begin
      check(shared_readback_flag_pin_oe_n, !(prev_mode || prev_act));
    end
    if (prev_mode) check(shared_readback_flag_pin_o, overrange_flag);
    prev_act = readback_active;
    prev_mode = pin_flag_mode;
    if (frame_strobe === 1'b1) begin
      ovr_hist <= {ovr_hist[30:0], sample_overrange};
      samp_hist <= {samp_hist[6:0], sample_in};
    end
  end
  // A fresh sample every clock.
  always @(negedge mclk) sample_in <= sample_in + 16'h1;
  // ==========
  // Scenarios
  // ==========
  // Bursts with gaps, so the countdown restarts while the flag is held.
  task automatic t_flag();
    logic [7:0] pat;
    logic [3:0] ex [3];
    pat = 8'h19;
    ex = '{4'h0, 4'h5, 4'hF};
    pin_flag_mode = 1'b1;
    repeat (12) @(negedge mclk);
    watch = 1'b1;
    foreach (ex[k]) begin
      release_extra = ex[k];
      for (int i = 0; i < 40; i++) begin
        sample_overrange = (i < 8) ? pat[i] : 1'b0;
        @(negedge mclk);
      end
    end
    watch = 1'b0;
    pin_flag_mode = 1'b0;
  endtask : t_flag
  // Readback owns the pin while flag mode is off, even with the flag high.
  task automatic t_readback();
    sample_overrange = 1'b1;
    readback_active = 1'b1;
    for (int i = 0; i < 24; i++) begin
      readback_data = i[0] ^ i[2];
      @(negedge mclk);
      check(shared_readback_flag_pin_o, readback_data);
      check(shared_readback_flag_pin_oe_n, 1'b0);
    end
    check(overrange_flag, 1'b1);
    sample_overrange = 1'b0;
    readback_active = 1'b0;
    readback_data = 1'b0;
    repeat (40) @(negedge mclk);
  endtask : t_readback
  // Enable low freezes the frame counter and the sample pipeline.
  task automatic t_freeze();
    logic [SAMPLE_W-1:0] held;
    clk_en = 1'b0;
    @(negedge mclk);
    held = boundary_sample;
    repeat (6) begin
      @(negedge mclk);
      check(frame_strobe, 1'b0);
      check(boundary_sample, held);
    end
    clk_en = 1'b1;
    repeat (2) @(negedge mclk);
  endtask : t_freeze
  // Every ratio code; code three behaves as divide by one.
  task automatic t_div();
    int n;
    for (int c = 0; c < 4; c++) begin
      clock_divide_ratio = 2'(c);
      // Strobes are looked at mid-cycle, where they have settled.
      repeat (9) @(negedge mclk);
      while (frame_strobe !== 1'b1) @(negedge mclk);
      n = 0;
      do begin
        @(negedge mclk);
        n++;
      end while (frame_strobe !== 1'b1 && n < 9);
      check(n, (c == 1) ? 2 : (c == 2) ? 4 : 1);
      @(negedge mclk);
    end
  endtask : t_div
  // Legal pulses at divide by four, then one high for a single frame.
  task automatic t_sysref();
    clock_divide_ratio = DIV_BY_4;
    events = 0;
    sysref_source_i.pulse(12, 12);
    sysref_source_i.pulse(12, 12);
    check(events, 2);
    check(sysref_width_error, 1'b0);
    sysref_source_i.pulse(4, 12);
    check(sysref_width_error, 1'b1);
  endtask : t_sysref
  // A reset clears the sticky error; then a low phase of one frame.
  task automatic t_sysref_low();
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    check(sysref_width_error, 1'b0);
    sysref_source_i.pulse(12, 4);
    sysref_source_i.pulse(12, 12);
    check(sysref_width_error, 1'b1);
  endtask : t_sysref_low
  initial begin
    {rst_n, sample_overrange, pin_flag_mode, readback_data} = 4'h0;
    {readback_active, watch, prev_act, prev_mode} = 4'h0;
    clk_en = 1'b1;
    clock_divide_ratio = DIV_BY_1;
    release_extra = 4'h0;
    sample_in = 16'h0;
    samp_hist = '0;
    ovr_hist = 32'h0;
    {miscompares, compares, cycles, events} = '0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    // Scenarios race a cycle ceiling; whichever ends first leads to the verdict.
    fork
      begin
        t_flag();
        t_readback();
        t_freeze();
        t_div();
        t_sysref();
        t_sysref_low();
      end
      begin
        wait (cycles == 3000);
        miscompares++;
      end
    join_any
    stop_test();
  end
endmodule : conv_timing_tb
`default_nettype wire
